//--- common/sync_dio_defs.svh
`ifndef SYNC_DIO_DEFS_SVH
`define SYNC_DIO_DEFS_SVH
// Function
// (RULE1) Detection needs its enable bit; continuous mode also needs the bit synchronizer on.
// (RULE2) Shift each demodulated bit in, compare every bit, raise the match flag.
// (RULE3) Earliest bit meets MSB of first byte, latest meets LSB of last byte.
// (RULE4) Match flag clears on leaving receive mode and when the FIFO empties; a hit in the cycle the FIFO empties keeps it set.
// (RULE5) Pattern length is one to eight bytes, also used for transmit pattern.
// (RULE6) Match when mismatching bits do not exceed the tolerance of zero to seven.
// (RULE7) The 64-bit pattern value serves receive compare and packet transmit.
// (RULE8) Software never programs a pattern byte equal to zero.
// (RULE9) Six pins each take a two-bit code; meaning depends on mode and data mode.
// (RULE10) Continuous receive code 00 routes clock, timeout, strength, data, bit clock, match.
// (RULE11) Continuous transmit code 00 routes clock, ready, ready, data, bit clock, lock.
// (RULE12) Packet receive code 00 routes full, not empty, level and check pass.
// (RULE13) Packet receive code 01 routes data, strength, strength, data, full, payload.
// (RULE14) Packet transmit code 00 routes settled, full, not empty, level, done.
// (RULE15) Packet receive data shows only between receiver-up and payload rising edges.
// (RULE16) Continuous mode exchanges raw bits on one two-way pin; packet engine idle.
// (RULE17) Continuous transmit captures the data pin at each bit clock rising edge.
// (RULE18) With shaping on, the controller paces its data by the bit clock.
// (RULE19) Continuous receive without synchronizer passes raw bits and gives no bit clock.
// (RULE20) With synchronizer, data changes on falling clock edges, sampled on rising.
// (RULE21) Packet mode routes data through the FIFO and enables the synchronizer.
// (RULE22) Packet mode lets the FIFO be used in sleep and standby.
// (RULE23) Not-empty low exactly when FIFO empty; full high only when all occupied.
// (RULE24) Transmit-done rises once the last shift register bit is sent.
// (RULE25) A pin whose code selects nothing is driven steadily low.
// (RULE26) A code or mode change reaches the pins within one clock cycle.

// Register byte offsets.
`define REG_CTRL 5'h00
`define REG_PCFG 5'h04
`define REG_PVAL_HI 5'h08
`define REG_PVAL_LO 5'h0C
`define REG_SEL_A 5'h10
`define REG_SEL_B 5'h14
`define REG_STATUS 5'h18

// Field positions.
`define CTRL_MODE 2:0
`define CTRL_PKT 3
`define CTRL_BSYNC 4
`define CTRL_DIV 15:8
`define PCFG_EN 7
`define PCFG_LEN 5:3
`define PCFG_TOL 2:0

// Reset values.
`define CTRL_RST 16'h0401
`define PCFG_RST 8'h98
`define PVAL_RST 64'h0101010101010101
`define SEL_RST 8'h00

// Pattern width limits.
`define PAT_MIN_BITS 7'h08
`define PAT_MAX_BITS 7'h40
`endif

//--- common/sync_dio_pkg.sv
package sync_dio_pkg;

    typedef enum logic [2:0] {
        M_SLEEP = 3'h0,
        M_STDBY = 3'h1,
        M_SYNTH = 3'h2,
        M_RX = 3'h3,
        M_TX = 3'h4
    } op_mode_t;

    typedef enum logic [4:0] {
        S_NO = 5'h00, S_CLK = 5'h01, S_MRDY = 5'h02, S_AUTO = 5'h03, S_LOCK = 5'h04,
        S_TOUT = 5'h05, S_RSSI = 5'h06, S_DATA = 5'h07, S_DCLK = 5'h08, S_HIT = 5'h09,
        S_RXUP = 5'h0A, S_TXUP = 5'h0B, S_FULL = 5'h0C, S_NE = 5'h0D, S_LVL = 5'h0E,
        S_CRC = 5'h0F, S_PAY = 5'h10, S_SENT = 5'h11
    } src_t;

    typedef struct packed {
        logic mode_settled_flag;
        logic auto_sequence_active;
        logic synth_locked_flag;
        logic rx_timeout;
        logic rssi_flag;
        logic receiver_up_flag;
        logic transmitter_up_flag;
        logic queue_full_flag;
        logic queue_has_bytes_flag;
        logic queue_threshold_flag;
        logic check_pass_flag;
        logic payload_available_flag;
        logic transmit_done_flag;
    } dev_status_t;

    typedef struct packed {
        logic raw_bit;
        logic clean_bit;
        logic pkt_tx_bit;
        logic bit_tick;
        logic half_tick;
    } modem_in_t;

    typedef struct packed {
        logic stall;
        logic [31:0] rdata;
        logic [15:0] ctrl;
        logic [7:0] pcfg;
        logic [63:0] pval;
        logic [7:0] sel_a;
        logic [7:0] sel_b;
        logic [63:0] shreg;
        logic match;
        logic rx_prev;
        logic ne_prev;
        logic rxup_prev;
        logic pay_prev;
        logic win;
        logic dclk;
        logic data;
        logic txbit;
        logic sync1;
        logic sync2;
        logic divided_reference_out;
        logic bsync_en;
        logic pkt_en;
        logic [7:0] div_cnt;
        logic [5:0] dio;
        logic [5:0] dio_oe;
    } core_state_t;

    // Source of each pin, packed as {pin5, pin4, pin3, pin2, pin1, pin0}.
    function automatic logic [29:0] route_row(input logic pkt, input logic [2:0] mode, input logic [1:0] code);
        logic [29:0] r;
        r = '0;
        unique case ({pkt, mode, code})
            {1'b0, M_SLEEP, 2'h2}, {1'b0, M_STDBY, 2'h2}, {1'b0, M_SYNTH, 2'h2}:
                r = {S_NO, S_NO, S_AUTO, S_NO, S_NO, S_NO};
            {1'b0, M_SLEEP, 2'h3}, {1'b0, M_STDBY, 2'h3}: r = {S_MRDY, S_NO, S_NO, S_NO, S_NO, S_MRDY};
            {1'b0, M_STDBY, 2'h0}: r = {S_CLK, S_NO, S_NO, S_NO, S_NO, S_NO};
            {1'b0, M_SYNTH, 2'h0}: r = {S_CLK, S_NO, S_NO, S_NO, S_NO, S_LOCK};
            {1'b0, M_SYNTH, 2'h3}: r = {S_MRDY, S_LOCK, S_NO, S_NO, S_LOCK, S_MRDY};
            {1'b0, M_RX, 2'h0}: r = {S_CLK, S_TOUT, S_RSSI, S_DATA, S_DCLK, S_HIT};
            {1'b0, M_RX, 2'h1}: r = {S_RSSI, S_RXUP, S_RXUP, S_DATA, S_RXUP, S_TOUT};
            {1'b0, M_RX, 2'h2}: r = {S_NO, S_HIT, S_AUTO, S_DATA, S_NO, S_RSSI};
            {1'b0, M_RX, 2'h3}: r = {S_MRDY, S_LOCK, S_TOUT, S_DATA, S_HIT, S_MRDY};
            {1'b0, M_TX, 2'h0}: r = {S_CLK, S_TXUP, S_TXUP, S_DATA, S_DCLK, S_LOCK};
            {1'b0, M_TX, 2'h1}: r = {S_CLK, S_TXUP, S_TXUP, S_DATA, S_TXUP, S_TXUP};
            {1'b0, M_TX, 2'h2}: r = {S_NO, S_NO, S_AUTO, S_DATA, S_NO, S_NO};
            {1'b0, M_TX, 2'h3}: r = {S_MRDY, S_LOCK, S_TXUP, S_DATA, S_LOCK, S_MRDY};
            {1'b1, M_SLEEP, 2'h0}: r = {S_NO, S_NO, S_FULL, S_NE, S_LVL, S_NO};
            {1'b1, M_STDBY, 2'h0}, {1'b1, M_SYNTH, 2'h0}: r = {S_CLK, S_NO, S_FULL, S_NE, S_LVL, S_NO};
            {1'b1, M_SLEEP, 2'h1}, {1'b1, M_STDBY, 2'h1}, {1'b1, M_SYNTH, 2'h1}:
                r = {S_NO, S_NO, S_NO, S_NO, S_FULL, S_NO};
            {1'b1, M_SLEEP, 2'h2}, {1'b1, M_STDBY, 2'h2}, {1'b1, M_SYNTH, 2'h2}, {1'b1, M_TX, 2'h2}:
                r = {S_NO, S_NO, S_NO, S_NO, S_NE, S_NO};
            {1'b1, M_SLEEP, 2'h3}, {1'b1, M_STDBY, 2'h3}: r = {S_MRDY, S_NO, S_NO, S_AUTO, S_NO, S_NO};
            {1'b1, M_SYNTH, 2'h3}, {1'b1, M_TX, 2'h3}: r = {S_MRDY, S_LOCK, S_LOCK, S_AUTO, S_LOCK, S_LOCK};
            {1'b1, M_RX, 2'h0}: r = {S_CLK, S_TOUT, S_FULL, S_NE, S_LVL, S_CRC};
            {1'b1, M_RX, 2'h1}: r = {S_DATA, S_RSSI, S_RSSI, S_DATA, S_FULL, S_PAY};
            {1'b1, M_RX, 2'h2}: r = {S_NO, S_RXUP, S_HIT, S_NO, S_NE, S_HIT};
            {1'b1, M_RX, 2'h3}: r = {S_MRDY, S_LOCK, S_LOCK, S_AUTO, S_TOUT, S_RSSI};
            {1'b1, M_TX, 2'h0}: r = {S_CLK, S_MRDY, S_FULL, S_NE, S_LVL, S_SENT};
            {1'b1, M_TX, 2'h1}: r = {S_DATA, S_TXUP, S_TXUP, S_DATA, S_FULL, S_TXUP};
            default: r = '0;
        endcase
        return r;
    endfunction

endpackage

//--- core/sync_dio_core.sv
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
`include "sync_dio_defs.svh"

module sync_dio_core (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic nrst_i,
    // Avalon-MM register slave.
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Device status and modem bit stream.
    input wire sync_dio_pkg::dev_status_t status_i,
    input wire sync_dio_pkg::modem_in_t modem_i,
    // Data pin from the controller.
    input wire logic serial_bit_pin_i,
    // IO pins.
    output logic [5:0] dio_o,
    output logic [5:0] dio_oe_o,
    // Towards modulator, packet engine and synchronizer.
    output logic tx_bit_o,
    output logic bsync_en_o,
    output logic packet_engine_en_o,
    output logic pattern_match_flag_o,
    output logic [63:0] tx_pattern_o,
    output logic [2:0] tx_pattern_len_o
);

    sync_dio_pkg::core_state_t q;
    sync_dio_pkg::core_state_t d;

    logic [2:0] mode;
    logic pkt;
    logic bsync;
    logic in_rx;
    logic in_tx;
    logic det_on;
    logic hit;
    logic clr;
    logic [6:0] nbits;
    logic [6:0] errs;
    logic [63:0] shifted;
    logic [31:0] rmux;
    logic [31:0] wv;
    logic [31:0] srcv;
    logic [29:0] row;
    logic [1:0] code;
    logic data_val;
    logic [29:0] row0;

    // Merges a bus write into a register word under its byte enables.
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Counts bits of the newest window that differ from the pattern's leading bytes.
    function automatic logic [6:0] count_errs(input logic [63:0] sh, input logic [63:0] pv, input logic [6:0] nb);
        logic [63:0] expv;
        logic [6:0] c;
        expv = pv >> (`PAT_MAX_BITS - nb);
        c = 7'h00;
        for (int i = 0; i < 64; i++)
        begin
            if ((7'(i) < nb) && (sh[i] != expv[i]))
            begin
                c = c + 7'h01;
            end
        end
        return c;
    endfunction

    // Selects the two-bit mapping code of one pin from the two select registers.
    function automatic logic [1:0] pin_code(input logic [7:0] sa, input logic [7:0] sb, input int p);
        logic [1:0] c;
        c = 2'h0;
        case (p)
            0: c = sa[7:6];
            1: c = sa[5:4];
            2: c = sa[3:2];
            3: c = sa[1:0];
            4: c = sb[7:6];
            default: c = sb[5:4];
        endcase
        return c;
    endfunction

    // Decoded operating state; packet mode forces the synchronizer on.
    assign mode = q.ctrl[`CTRL_MODE];
    assign pkt = q.ctrl[`CTRL_PKT];
    assign bsync = pkt | q.ctrl[`CTRL_BSYNC]; // RULE21
    assign in_rx = (mode == sync_dio_pkg::M_RX);
    assign in_tx = (mode == sync_dio_pkg::M_TX);

    // Pattern compare on the window that includes the bit just arriving.
    assign nbits = {1'b0, q.pcfg[`PCFG_LEN], 3'b000} + `PAT_MIN_BITS; // RULE5
    assign det_on = q.pcfg[`PCFG_EN] && in_rx && bsync; // RULE1
    assign shifted = {q.shreg[62:0], modem_i.clean_bit}; // RULE2
    assign errs = count_errs(shifted, q.pval, nbits); // RULE3
    assign hit = det_on && modem_i.bit_tick && (errs <= {4'h0, q.pcfg[`PCFG_TOL]}); // RULE6
    assign clr = (q.rx_prev && !in_rx) || (q.ne_prev && !status_i.queue_has_bytes_flag); // RULE4
    assign data_val = (pkt && in_rx) ? (q.win && q.data) : q.data; // RULE15
    assign row0 = sync_dio_pkg::route_row(pkt, mode, q.sel_a[7:6]);

    // Register read view of the current address.
    always_comb
    begin
        rmux = 32'h0000_0000;
        case (avs_address_i)
            `REG_CTRL: rmux = {16'h0000, q.ctrl};
            `REG_PCFG: rmux = {24'h000000, q.pcfg};
            `REG_PVAL_HI: rmux = q.pval[63:32];
            `REG_PVAL_LO: rmux = q.pval[31:0];
            `REG_SEL_A: rmux = {24'h000000, q.sel_a};
            `REG_SEL_B: rmux = {24'h000000, q.sel_b};
            `REG_STATUS: rmux = {18'h00000, q.dio, 6'h00, q.win, q.match};
            default: rmux = 32'h0000_0000;
        endcase
    end

    // Signal sources indexed by their source code; code zero stays low.
    always_comb
    begin
        srcv = 32'h0000_0000;
        srcv[sync_dio_pkg::S_CLK] = q.divided_reference_out;
        srcv[sync_dio_pkg::S_MRDY] = status_i.mode_settled_flag;
        srcv[sync_dio_pkg::S_AUTO] = status_i.auto_sequence_active;
        srcv[sync_dio_pkg::S_LOCK] = status_i.synth_locked_flag;
        srcv[sync_dio_pkg::S_TOUT] = status_i.rx_timeout;
        srcv[sync_dio_pkg::S_RSSI] = status_i.rssi_flag;
        srcv[sync_dio_pkg::S_DATA] = data_val;
        srcv[sync_dio_pkg::S_DCLK] = q.dclk;
        srcv[sync_dio_pkg::S_HIT] = q.match;
        srcv[sync_dio_pkg::S_RXUP] = status_i.receiver_up_flag;
        srcv[sync_dio_pkg::S_TXUP] = status_i.transmitter_up_flag;
        srcv[sync_dio_pkg::S_FULL] = status_i.queue_full_flag; // RULE23
        srcv[sync_dio_pkg::S_NE] = status_i.queue_has_bytes_flag; // RULE23
        srcv[sync_dio_pkg::S_LVL] = status_i.queue_threshold_flag;
        srcv[sync_dio_pkg::S_CRC] = status_i.check_pass_flag;
        srcv[sync_dio_pkg::S_PAY] = status_i.payload_available_flag;
        srcv[sync_dio_pkg::S_SENT] = status_i.transmit_done_flag; // RULE24
    end

    // Next-state logic of the whole block.
    always_comb
    begin
        d = q;
        wv = be_merge(rmux, avs_writedata_i, avs_byteenable_i);
        row = 30'h0;
        code = 2'h0;
        // Bus: one wait state, read data captured, writes commit when waitrequest is low.
        d.stall = 1'b1;
        if ((avs_read_i || avs_write_i) && q.stall)
        begin
            d.stall = 1'b0;
            d.rdata = rmux;
        end
        if (avs_write_i && !q.stall)
        begin
            case (avs_address_i)
                `REG_CTRL: d.ctrl = wv[15:0];
                `REG_PCFG: d.pcfg = wv[7:0];
                `REG_PVAL_HI: d.pval[63:32] = wv; // RULE7
                `REG_PVAL_LO: d.pval[31:0] = wv; // RULE7
                `REG_SEL_A: d.sel_a = wv[7:0];
                `REG_SEL_B: d.sel_b = wv[7:0];
                default: d.stall = 1'b1;
            endcase
        end
        // Engine enables follow the data mode and the synchronizer bit in every operating mode.
        d.bsync_en = bsync; // RULE21
        d.pkt_en = pkt; // RULE16 RULE22
        // Two-stage synchroniser for the controller's data pin.
        d.sync1 = serial_bit_pin_i;
        d.sync2 = q.sync1;
        // Pattern shift register and sticky match flag; a hit beats a clear.
        if (!in_rx)
        begin
            d.shreg = 64'h0;
        end
        else if (det_on && modem_i.bit_tick)
        begin
            d.shreg = shifted; // RULE2
        end
        if (hit)
        begin
            d.match = 1'b1; // RULE2
        end
        else if (clr)
        begin
            d.match = 1'b0; // RULE4
        end
        d.rx_prev = in_rx;
        d.ne_prev = status_i.queue_has_bytes_flag;
        // Packet receive data window between receiver-up and payload rising edges.
        d.rxup_prev = status_i.receiver_up_flag;
        d.pay_prev = status_i.payload_available_flag;
        if (!in_rx)
        begin
            d.win = 1'b0;
        end
        else if (status_i.receiver_up_flag && !q.rxup_prev)
        begin
            d.win = 1'b1; // RULE15
        end
        else if (status_i.payload_available_flag && !q.pay_prev)
        begin
            d.win = 1'b0; // RULE15
        end
        // Serial data and bit clock.
        if (in_rx && !bsync)
        begin
            d.data = modem_i.raw_bit; // RULE19
            d.dclk = 1'b0; // RULE19
        end
        else if (in_rx)
        begin
            if (modem_i.bit_tick)
            begin
                d.data = modem_i.clean_bit; // RULE20
                d.dclk = 1'b0; // RULE20
            end
            else if (modem_i.half_tick)
            begin
                d.dclk = 1'b1; // RULE20
            end
        end
        else if (in_tx)
        begin
            if (modem_i.bit_tick)
            begin
                d.dclk = 1'b1; // RULE17
                if (pkt)
                begin
                    d.data = modem_i.pkt_tx_bit;
                end
                else
                begin
                    d.txbit = q.sync2; // RULE17 RULE18
                    d.data = q.sync2;
                end
            end
            else if (modem_i.half_tick)
            begin
                d.dclk = 1'b0;
            end
        end
        else
        begin
            d.dclk = 1'b0;
        end
        // Divided reference output, stopped in sleep.
        if (mode == sync_dio_pkg::M_SLEEP)
        begin
            d.div_cnt = 8'h00;
            d.divided_reference_out = 1'b0;
        end
        else if (q.div_cnt >= q.ctrl[`CTRL_DIV])
        begin
            d.div_cnt = 8'h00;
            d.divided_reference_out = !q.divided_reference_out;
        end
        else
        begin
            d.div_cnt = q.div_cnt + 8'h01;
        end
        // Pin multiplexer, registered so a change lands on the next edge.
        for (int p = 0; p < 6; p++)
        begin
            code = pin_code(q.sel_a, q.sel_b, p);
            row = sync_dio_pkg::route_row(pkt, mode, code); // RULE9
            d.dio[p] = srcv[row[5*p +: 5]]; // RULE10 RULE11 RULE12 RULE13 RULE14 RULE25 RULE26
        end
        d.dio_oe = 6'h3F;
        d.dio_oe[2] = !(in_tx && !pkt); // RULE16
    end

    // State register.
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            q <= '0;
            q.stall <= 1'b1;
            q.ctrl <= `CTRL_RST;
            q.pcfg <= `PCFG_RST;
            q.pval <= `PVAL_RST;
            q.sel_a <= `SEL_RST;
            q.sel_b <= `SEL_RST;
            q.dio_oe <= 6'h3F;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from the state register.
    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = q.stall;
    assign dio_o = q.dio;
    assign dio_oe_o = q.dio_oe;
    assign tx_bit_o = q.txbit;
    assign bsync_en_o = q.bsync_en;
    assign packet_engine_en_o = q.pkt_en;
    assign pattern_match_flag_o = q.match;
    assign tx_pattern_o = q.pval;
    assign tx_pattern_len_o = q.pcfg[`PCFG_LEN];

    // Checks of the block's behaviour.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_leave_rx;
        $fell(in_rx);
    endsequence

    sequence s_cont_tx_tick;
        in_tx && !pkt && modem_i.bit_tick;
    endsequence

    chk_match_leave_rx: assert property (s_leave_rx |=> !q.match ##1 !q.match) // RULE4
        else $error("match flag survived leaving receive mode");
    chk_match_on_empty: assert property (q.ne_prev && !status_i.queue_has_bytes_flag && !hit |=> !q.match) // RULE4
        else $error("match flag survived an emptied queue");
    chk_match_needs_enable: assert property ($rose(q.match) |-> $past(det_on) && ($past(errs) <= 7'h07)) // RULE1
        else $error("match flag rose without detection enabled");
    chk_match_tolerance: assert property (det_on && modem_i.bit_tick && errs <= {4'h0, q.pcfg[`PCFG_TOL]}
        |=> q.match) // RULE6
        else $error("pattern within tolerance not flagged");
    chk_tx_capture: assert property (s_cont_tx_tick |=> q.dclk && (q.txbit == $past(q.sync2))) // RULE17
        else $error("data pin not captured at bit clock rise");
    chk_rx_falling: assert property (in_rx && bsync && modem_i.bit_tick
        |=> !q.dclk && (q.data == $past(modem_i.clean_bit))) // RULE20
        else $error("receive data not updated on falling bit clock");
    chk_raw_pass: assert property (in_rx && !bsync |=> !q.dclk && (q.data == $past(modem_i.raw_bit))) // RULE19
        else $error("raw demodulator bit not passed through");
    chk_pin_idle: assert property (row0[4:0] == sync_dio_pkg::S_NO |=> !q.dio[0]) // RULE25
        else $error("unselected pin not held low");
    chk_cont_rx_hit: assert property (in_rx && !pkt && q.sel_a[7:6] == 2'h0 |=> q.dio[0] == $past(q.match)) // RULE10
        else $error("pin 0 does not follow the match flag");
    chk_window_close: assert property (in_rx && $rose(status_i.payload_available_flag)
        && !$rose(status_i.receiver_up_flag) |=> !q.win) // RULE15
        else $error("data window open after payload ready");
    chk_bsync_auto: assert property (pkt |=> q.bsync_en && q.pkt_en) // RULE21
        else $error("packet mode did not enable synchronizer");

endmodule

//--- verification/mcu_model.sv
`timescale 1ns/100ps
// Controller on the pins: paces its data by the bit clock and collects received data.
module mcu_model (
    // Clock and pins.
    input wire logic clk_i,
    input wire logic [5:0] dio_i,
    input wire logic [5:0] dio_oe_i,
    input wire logic [7:0] tx_byte_i,
    // Data pin drive and collected byte.
    output logic pin_o,
    output logic [7:0] rx_byte_o
);
    logic dclk_q = 1'b0;
    logic junk_q = 1'b0;
    logic [2:0] idx_q = 3'h7;
    // A released pin shows a toggling level, so a stale bit is never mistaken for data.
    assign pin_o = dio_oe_i[2] ? junk_q : tx_byte_i[idx_q];
    // Next bit goes out on the falling bit clock, received bits are taken on the rising one.
    always_ff @(posedge clk_i)
    begin
        dclk_q <= dio_i[1];
        junk_q <= ~junk_q;
        if (dio_oe_i[2])
            idx_q <= 3'h7;
        else if (dclk_q && !dio_i[1])
            idx_q <= idx_q - 3'h1;
        if (!dclk_q && dio_i[1])
            rx_byte_o <= {rx_byte_o[6:0], dio_i[2]};
    end
endmodule

//--- verification/sync_detect_and_dio_routing_tb_top.sv
`timescale 1ns/100ps
`include "sync_dio_defs.svh"
module sync_detect_and_dio_routing_tb_top;
    logic clk, nrst, rd, wr, wt, pin, txb, bse, pke, mf;
    logic [4:0] adr;
    logic [31:0] wd, rdat, q;
    logic [12:0] st;
    sync_dio_pkg::modem_in_t md;
    logic [5:0] dio, oe;
    logic [63:0] pat;
    logic [2:0] plen;
    logic [7:0] rxb;
    logic [7:0] txbyte = 8'h96;
    int n_fail = 0;
    int num_checks = 0;
    // Block under test and the controller on its pins.
    sync_dio_core i_sync_dio_core (.clk_i(clk), .nrst_i(nrst), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .status_i(st), .modem_i(md), .serial_bit_pin_i(pin), .dio_o(dio),
        .dio_oe_o(oe), .tx_bit_o(txb), .bsync_en_o(bse), .packet_engine_en_o(pke),
        .pattern_match_flag_o(mf), .tx_pattern_o(pat), .tx_pattern_len_o(plen));
    mcu_model i_mcu_model (.clk_i(clk), .dio_i(dio), .dio_oe_i(oe), .tx_byte_i(txbyte), .pin_o(pin),
        .rx_byte_o(rxb));
    // Free-running clock.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Prints the counts and the verdict, then stops.
    task automatic conclude;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Compares a seen value with the expected one.
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        num_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("ERROR at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // One bus transfer, held until waitrequest is seen low; a hang ends the run.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        while (wt !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (wt !== 1'b0)
        begin
            n_fail++;
            conclude();
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Reads a register and compares it.
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Lets registered outputs settle.
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    // One modem bit: two spare cycles let the pin cross the synchroniser, then the two pulses.
    task automatic tk(input logic b);
        repeat (2) @(posedge clk);
        md <= {b, b, 3'b010};
        @(posedge clk);
        md.bit_tick <= 1'b0;
        repeat (3) @(posedge clk);
        md.half_tick <= 1'b1;
        @(posedge clk);
        md.half_tick <= 1'b0;
        settle();
    endtask
    // Eight modem bits, earliest first.
    task automatic sendb(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            tk(b[i]);
    endtask
    // Puts one code on every pin, raises one status flag and checks the pins one cycle later.
    task automatic pc(input logic [15:0] c, input logic [1:0] k, input int bi, input logic [5:0] e,
        input logic [5:0] m);
        bus(1'b1, `REG_CTRL, {16'h0, c});
        bus(1'b1, `REG_SEL_A, {24'h0, {4{k}}});
        bus(1'b1, `REG_SEL_B, {24'h0, k, k, 4'h0});
        @(posedge clk);
        st <= 13'h1 << bi;
        @(posedge clk);
        @(negedge clk);
        chk(dio & m, e);
    endtask
    // Main sequence: reset, pin routing, pattern detection, data paths.
    initial
    begin
        {nrst, rd, wr, adr, wd, st, md} <= '0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rdc(`REG_PVAL_LO, 32'h01010101);
        rdc(5'h1C, 32'h0);
        pc(16'h0403, 2'h0, 9, 6'h10, 6'h1F);
        pc(16'h0403, 2'h0, 8, 6'h08, 6'h1F);
        pc(16'h0404, 2'h0, 6, 6'h18, 6'h1B);
        pc(16'h0404, 2'h0, 10, 6'h01, 6'h1B);
        pc(16'h040B, 2'h0, 5, 6'h08, 6'h1F);
        pc(16'h040B, 2'h0, 4, 6'h04, 6'h1F);
        pc(16'h040B, 2'h0, 3, 6'h02, 6'h1F);
        pc(16'h040B, 2'h0, 2, 6'h01, 6'h1F);
        pc(16'h040B, 2'h1, 8, 6'h18, 6'h1F);
        pc(16'h040B, 2'h1, 5, 6'h02, 6'h1F);
        pc(16'h040B, 2'h1, 1, 6'h01, 6'h1F);
        pc(16'h040C, 2'h0, 12, 6'h10, 6'h1F);
        pc(16'h040C, 2'h0, 5, 6'h08, 6'h1F);
        pc(16'h040C, 2'h0, 4, 6'h04, 6'h1F);
        pc(16'h040C, 2'h0, 3, 6'h02, 6'h1F);
        pc(16'h040C, 2'h0, 0, 6'h01, 6'h1F);
        for (int i = 0; i < 13; i++)
            pc(16'h0400, 2'h1, i, 6'h00, 6'h3F);
        st <= '0;
        rdc(`REG_SEL_B, 32'h50);
        bus(1'b1, `REG_SEL_A, 32'h0);
        bus(1'b1, `REG_PVAL_HI, 32'hB41E0101);
        bus(1'b1, `REG_PCFG, 32'h80);
        bus(1'b1, `REG_CTRL, 32'h0413);
        sendb(8'hFF);
        sendb(8'hB5);
        chk(mf, 1'b0);
        sendb(8'hB4);
        chk(mf, 1'b1);
        chk(rxb, 8'hB4);
        bus(1'b1, `REG_CTRL, 32'h0411);
        settle();
        chk(mf, 1'b0);
        bus(1'b1, `REG_PCFG, 32'h88);
        bus(1'b1, `REG_CTRL, 32'h0413);
        sendb(8'hB4);
        chk(mf, 1'b0);
        sendb(8'h1F);
        chk(mf, 1'b0);
        bus(1'b1, `REG_PCFG, 32'h89);
        sendb(8'hB4);
        sendb(8'h1F);
        chk(mf, 1'b1);
        chk(pat, 64'hB41E010101010101);
        chk(plen, 3'h1);
        @(posedge clk);
        st <= 13'h010;
        @(posedge clk);
        st <= 13'h000;
        settle();
        chk(mf, 1'b0);
        bus(1'b1, `REG_PCFG, 32'h09);
        sendb(8'hB4);
        sendb(8'h1E);
        chk(mf, 1'b0);
        bus(1'b1, `REG_PCFG, 32'h88);
        bus(1'b1, `REG_CTRL, 32'h0403);
        sendb(8'hB4);
        sendb(8'h1E);
        chk(mf, 1'b0);
        @(posedge clk);
        md <= 5'b10001;
        @(posedge clk);
        md <= 5'b10000;
        settle();
        chk({dio[2:1], pke}, 3'b100);
        bus(1'b1, `REG_CTRL, 32'h0404);
        repeat (4) @(posedge clk);
        chk(oe, 6'h3B);
        for (int i = 7; i >= 0; i--)
        begin
            tk(1'b0);
            chk(txb, txbyte[i]);
        end
        bus(1'b1, `REG_CTRL, 32'h040B);
        bus(1'b1, `REG_SEL_A, 32'h55);
        bus(1'b1, `REG_SEL_B, 32'h50);
        st <= 13'h002;
        tk(1'b1);
        chk({dio[5], dio[2], bse, pke}, 4'b0011);
        st <= 13'h082;
        tk(1'b1);
        chk({dio[5], dio[2]}, 2'b11);
        st <= 13'h080;
        tk(1'b1);
        st <= 13'h082;
        tk(1'b1);
        chk({dio[5], dio[2]}, 2'b00);
        bus(1'b1, `REG_CTRL, 32'h0408);
        settle();
        chk({bse, pke}, 2'b11);
        conclude();
    end
endmodule
